// ===== core/dpr_regs.vh
// Constants for the dual-ported DMA buffer RAM.
// Assumes a 16 Kbyte byte-addressed data space with the RAM at its top.
`ifndef DPR_REGS_VH
`define DPR_REGS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define DPR_SIZE_BYTES 2048
`define DPR_ADDR_W 16
`define DPR_WORD_AW 10
`define DPR_DATA_W 16
`define DPR_LANE_W 8
`define DPR_LANES 2

// ----------------------------------------
// Placement in data space
// ----------------------------------------
`define DPR_TOP_BYTE 16'h3fff
`define DPR_BASE 16'h3800

// ----------------------------------------
// Field positions of a byte address
// ----------------------------------------
`define DPR_LANE_BIT 0
`define DPR_WORD_LSB 1
`define DPR_WORD_MSB 10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DPR_RDATA_RST 16'h0000

`endif

// ===== core/dpr_lane.v
// One byte-wide lane of the dual-ported RAM storage.
// Assumes write enables already resolved against collisions by the caller.
`timescale 1ns/1ns
module dpr_lane #(
    parameter AW = 10,
    parameter DW = 8
) (
    // Clock
    input wire clk_in,
    // Processor side
    input wire [AW-1:0] cpu_addr_in,
    input wire cpu_we_in,
    input wire [DW-1:0] cpu_data_in,
    output reg [DW-1:0] cpu_q_out,
    // Dma side
    input wire [AW-1:0] dma_addr_in,
    input wire dma_we_in,
    input wire [DW-1:0] dma_data_in,
    output reg [DW-1:0] dma_q_out
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Reads see the old word: read-before-write on both ports
    always @(posedge clk_in) begin
        cpu_q_out <= mem[cpu_addr_in];
        dma_q_out <= mem[dma_addr_in];
        if (dma_we_in) begin
            mem[dma_addr_in] <= dma_data_in;
        end
        if (cpu_we_in) begin
            mem[cpu_addr_in] <= cpu_data_in;
        end
    end

endmodule

// ===== core/dpr_ram.v
// Dual-ported data RAM shared by the processor core and the DMA engine.
// Assumes both ports are synchronous to clk_in; RAM contents are not reset.
// Assumes word accesses are even-aligned; address bit 0 only picks a byte lane.
//
// Contract
// - Two Kbyte dual-ported RAM at top of data space, processor and DMA ports.
// - Both ports reach any location in the same cycle, independently.
// - DMA engine keeps outgoing and incoming peripheral data in this RAM.
// - DMA traffic never steals processor cycles nor adds processor wait states.
// - Same-location simultaneous writes: processor write takes priority.
// - Without DMA the processor uses the RAM as plain data storage.
// - Two byte lanes share word decode; byte writes touch only the addressed lane.
`timescale 1ns/1ns
`include "dpr_regs.vh"
module dpr_ram #(
    parameter BASE = `DPR_BASE,
    parameter AW = `DPR_WORD_AW
) (
    // Clock and reset
    input wire clk_in,
    input wire resetn_in,
    // Processor port
    input wire cpu_en_in,
    input wire cpu_wr_in,
    input wire cpu_byte_in,
    input wire [`DPR_ADDR_W-1:0] cpu_addr_in,
    input wire [`DPR_DATA_W-1:0] cpu_wdata_in,
    output reg [`DPR_DATA_W-1:0] cpu_rdata_out,
    output wire cpu_ready_out,
    output reg cpu_hit_out,
    // Dma port
    input wire dma_en_in,
    input wire dma_wr_in,
    input wire dma_byte_in,
    input wire [`DPR_ADDR_W-1:0] dma_addr_in,
    input wire [`DPR_DATA_W-1:0] dma_wdata_in,
    output reg [`DPR_DATA_W-1:0] dma_rdata_out,
    output reg dma_hit_out,
    output reg dma_lost_out
);

    localparam [`DPR_ADDR_W-1:0] BASE_A = BASE;
    localparam [`DPR_ADDR_W-1:0] SPAN_MASK = `DPR_TOP_BYTE - `DPR_BASE;
    // Top of window follows the base; only a 2 Kbyte-aligned base keeps the full span
    localparam [`DPR_ADDR_W-1:0] TOP_A = BASE_A | SPAN_MASK;

    reg cpu_in_win;
    reg dma_in_win;
    wire same_word;
    wire cpu_act;
    wire dma_act;
    wire [AW-1:0] cpu_word;
    wire [AW-1:0] dma_word;
    wire [`DPR_LANES-1:0] cpu_lane_we;
    wire [`DPR_LANES-1:0] dma_lane_we;
    wire [`DPR_LANES-1:0] dma_lane_ok;
    wire [`DPR_DATA_W-1:0] cpu_q;
    wire [`DPR_DATA_W-1:0] dma_q;
    reg cpu_rd_r;
    reg cpu_sel_r;
    reg cpu_bsel_r;
    reg dma_rd_r;
    reg dma_sel_r;
    reg dma_bsel_r;
    reg [`DPR_DATA_W-1:0] cpu_rdata_nxt;
    reg [`DPR_DATA_W-1:0] dma_rdata_nxt;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Window is the top 2 Kbytes of implemented data space; anything else misses
    always @* begin
        cpu_in_win = 1'b0;
        if (cpu_addr_in < BASE_A) begin
            cpu_in_win = 1'b0;
        end else if (cpu_addr_in <= TOP_A) begin
            cpu_in_win = 1'b1;
        end else begin
            cpu_in_win = 1'b0;
        end
    end

    always @* begin
        dma_in_win = 1'b0;
        if (dma_addr_in < BASE_A) begin
            dma_in_win = 1'b0;
        end else if (dma_addr_in <= TOP_A) begin
            dma_in_win = 1'b1;
        end else begin
            dma_in_win = 1'b0;
        end
    end

    // ----------------------------------------
    // Port activity and word select
    // ----------------------------------------
    // Out-of-window requests never reach the lanes, so they cannot write
    assign cpu_act = cpu_en_in & cpu_in_win;
    // DMA port needs no mode switch; idle DMA simply leaves RAM to the core
    assign dma_act = dma_en_in & dma_in_win;
    assign cpu_word = cpu_addr_in[`DPR_WORD_MSB:`DPR_WORD_LSB];
    assign dma_word = dma_addr_in[`DPR_WORD_MSB:`DPR_WORD_LSB];

    // Processor never waits: no arbitration stalls it
    assign cpu_ready_out = 1'b1;

    // One word compare serves the collision guard of both lanes
    assign same_word = cpu_word == dma_word;

    // ----------------------------------------
    // Lane write enables and collision guard
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `DPR_LANES; g = g + 1) begin : lane_g
            // Byte write hits only the lane picked by address bit 0
            assign cpu_lane_we[g] = cpu_act & cpu_wr_in &
                (~cpu_byte_in | (cpu_addr_in[`DPR_LANE_BIT] == g));
            assign dma_lane_we[g] = dma_act & dma_wr_in &
                (~dma_byte_in | (dma_addr_in[`DPR_LANE_BIT] == g));
            // Per-lane: DMA loses only where the core writes the same byte
            assign dma_lane_ok[g] = dma_lane_we[g] &
                ~(cpu_lane_we[g] & same_word);
            // Collision reads need nothing here: each lane reads before it writes
            dpr_lane #(
                .AW(AW),
                .DW(`DPR_LANE_W)
            ) u_lane (
                .clk_in(clk_in),
                .cpu_addr_in(cpu_word),
                .cpu_we_in(cpu_lane_we[g]),
                .cpu_data_in(cpu_wdata_in[g*`DPR_LANE_W +: `DPR_LANE_W]),
                .cpu_q_out(cpu_q[g*`DPR_LANE_W +: `DPR_LANE_W]),
                .dma_addr_in(dma_word),
                .dma_we_in(dma_lane_ok[g]),
                .dma_data_in(dma_wdata_in[g*`DPR_LANE_W +: `DPR_LANE_W]),
                .dma_q_out(dma_q[g*`DPR_LANE_W +: `DPR_LANE_W])
            );
        end
    endgenerate

    // ----------------------------------------
    // Processor read stage
    // ----------------------------------------
    // Remembers what the lanes were asked for so the byte is picked next cycle
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cpu_rd_r <= 1'b0;
            cpu_sel_r <= 1'b0;
            cpu_bsel_r <= 1'b0;
            cpu_hit_out <= 1'b0;
        end else begin
            cpu_rd_r <= cpu_en_in & ~cpu_wr_in;
            cpu_sel_r <= cpu_addr_in[`DPR_LANE_BIT];
            cpu_bsel_r <= cpu_byte_in;
            cpu_hit_out <= cpu_act;
        end
    end

    // Byte reads land in the low byte; outside the window reads are zero
    always @* begin
        cpu_rdata_nxt = {`DPR_DATA_W{1'b0}};
        if (cpu_rd_r & cpu_hit_out) begin
            if (cpu_bsel_r) begin
                cpu_rdata_nxt = {8'h00, cpu_sel_r ? cpu_q[15:8] : cpu_q[7:0]};
            end else begin
                cpu_rdata_nxt = cpu_q;
            end
        end
    end

    // ----------------------------------------
    // DMA read stage
    // ----------------------------------------
    // Same pipe as the core port; a lost write is only flagged, never retried
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dma_rd_r <= 1'b0;
            dma_sel_r <= 1'b0;
            dma_bsel_r <= 1'b0;
            dma_hit_out <= 1'b0;
            dma_lost_out <= 1'b0;
        end else begin
            dma_rd_r <= dma_en_in & ~dma_wr_in;
            dma_sel_r <= dma_addr_in[`DPR_LANE_BIT];
            dma_bsel_r <= dma_byte_in;
            dma_hit_out <= dma_act;
            dma_lost_out <= |(dma_lane_we & ~dma_lane_ok);
        end
    end

    // Byte reads land in the low byte; outside the window reads are zero
    always @* begin
        dma_rdata_nxt = {`DPR_DATA_W{1'b0}};
        if (dma_rd_r & dma_hit_out) begin
            if (dma_bsel_r) begin
                dma_rdata_nxt = {8'h00, dma_sel_r ? dma_q[15:8] : dma_q[7:0]};
            end else begin
                dma_rdata_nxt = dma_q;
            end
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Registered again so data outputs come from flip-flops
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cpu_rdata_out <= `DPR_RDATA_RST;
        end else begin
            cpu_rdata_out <= cpu_rdata_nxt;
        end
    end

    // Kept apart from the core's register: neither port's data waits on the other
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dma_rdata_out <= `DPR_RDATA_RST;
        end else begin
            dma_rdata_out <= dma_rdata_nxt;
        end
    end

endmodule

// ===== testbench/dpr_ram_props.sv
// Port checker for dpr_ram, bound to every instance.
// Assumes one clock, both ports sampled on its rising edge.
`timescale 1ns/1ns
module dpr_ram_props #(parameter BASE = 16'h3800, parameter AW = 10) (
    input wire clk_in, resetn_in,
    input wire cpu_en_in, cpu_wr_in, cpu_byte_in, cpu_ready_out, cpu_hit_out,
    input wire dma_en_in, dma_wr_in, dma_byte_in, dma_hit_out, dma_lost_out,
    input wire [15:0] cpu_addr_in, cpu_wdata_in, cpu_rdata_out,
    input wire [15:0] dma_addr_in, dma_wdata_in, dma_rdata_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    wire cw = cpu_addr_in[15:11] == BASE[15:11];
    wire dw = dma_addr_in[15:11] == BASE[15:11];
    wire [1:0] cm = cpu_byte_in ? {cpu_addr_in[0], !cpu_addr_in[0]} : 2'h3;
    wire [1:0] dm = dma_byte_in ? {dma_addr_in[0], !dma_addr_in[0]} : 2'h3;
    wire cwe = cpu_en_in && cpu_wr_in && cw;
    wire clash = cwe && dma_en_in && dma_wr_in && (cm & dm) != 2'h0
        && cpu_addr_in[15:1] == dma_addr_in[15:1];
    wire crd = cpu_en_in && !cpu_wr_in && cw;
    wire drd = dma_en_in && !dma_wr_in && dw;
    no_stall_a: assert property (cpu_ready_out) else $error("cpu stalled");
    cpu_hit_a: assert property ($past(resetn_in) |->
        cpu_hit_out == $past(cpu_en_in && cw)) else $error("cpu hit wrong");
    dma_hit_a: assert property ($past(resetn_in) |->
        dma_hit_out == $past(dma_en_in && dw)) else $error("dma hit wrong");
    dma_lost_a: assert property ($past(resetn_in) |->
        dma_lost_out == $past(clash)) else $error("dma lost wrong");
    cpu_zero_a: assert property (!crd |-> ##2 cpu_rdata_out == 16'h0)
        else $error("cpu rdata not zero");
    dma_zero_a: assert property (!drd |-> ##2 dma_rdata_out == 16'h0)
        else $error("dma rdata not zero");
    byte_lane_a: assert property (crd && cpu_byte_in |->
        ##2 cpu_rdata_out[15:8] == 8'h00) else $error("byte read upper lane set");
    cpu_rdback_a: assert property ((cwe && !cpu_byte_in) ##1 (crd && !cpu_byte_in
        && cpu_addr_in[15:1] == $past(cpu_addr_in[15:1]))
        |-> ##2 cpu_rdata_out == $past(cpu_wdata_in, 3)) else $error("cpu readback wrong");
    dma_sees_a: assert property ((cwe && !cpu_byte_in) ##1 (drd && !dma_byte_in
        && dma_addr_in[15:1] == $past(cpu_addr_in[15:1]))
        |-> ##2 dma_rdata_out == $past(cpu_wdata_in, 3)) else $error("dma readback wrong");
    cover property (clash);
    cover property (crd && drd);
    cover property (cwe && cpu_byte_in);
endmodule
bind dpr_ram dpr_ram_props #(.BASE(BASE), .AW(AW)) u_props (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .cpu_en_in(cpu_en_in), .cpu_wr_in(cpu_wr_in), .cpu_byte_in(cpu_byte_in),
    .cpu_ready_out(cpu_ready_out), .cpu_hit_out(cpu_hit_out),
    .dma_en_in(dma_en_in), .dma_wr_in(dma_wr_in), .dma_byte_in(dma_byte_in),
    .dma_hit_out(dma_hit_out), .dma_lost_out(dma_lost_out),
    .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
    .dma_addr_in(dma_addr_in), .dma_wdata_in(dma_wdata_in), .dma_rdata_out(dma_rdata_out)
);

// ===== testbench/dpr_port_model.sv
// Requester model for one RAM port, processor or DMA engine.
// Assumes the bench posts a request just after a rising edge.
`timescale 1ns/1ns
module dpr_port_model (
    input wire clk_in,
    input wire [34:0] req_in,
    output reg [34:0] q_out
);
    initial q_out = 35'h0;
    // Idle cycles scramble address and data so nothing stale is trusted
    always @(negedge clk_in) begin
        q_out <= req_in[34] ? req_in : {1'b0, q_out[33:32], ~q_out[31:0]};
    end
endmodule

// ===== testbench/dual_port_dma_ram_tb_top.sv
// Self-checking bench for dpr_ram, one requester model per port.
// Assumes a 2-cycle read pipe and a 1-cycle hit and lost flag.
`timescale 1ns/1ns
module dual_port_dma_ram_tb_top;
    reg clk_in = 1'b0;
    reg resetn_in = 1'b0;
    reg [34:0] creq = 35'h0, dreq = 35'h0;
    wire [34:0] cq, dq;
    wire cpu_en_in, cpu_wr_in, cpu_byte_in, dma_en_in, dma_wr_in, dma_byte_in;
    wire [15:0] cpu_addr_in, cpu_wdata_in, dma_addr_in, dma_wdata_in;
    wire [15:0] cpu_rdata_out, dma_rdata_out;
    wire cpu_ready_out, cpu_hit_out, dma_hit_out, dma_lost_out;
    reg [15:0] mem [0:1023];
    reg [15:0] ec [0:1], ed [0:1];
    reg [2:0] eh = 3'h0;
    integer seed = 43, miscompares = 0, n_compared = 0, cyc = 0, i;
    reg [31:0] r;
    always #20 clk_in = ~clk_in;
    dpr_port_model u_cpu (.clk_in(clk_in), .req_in(creq), .q_out(cq));
    dpr_port_model u_dma (.clk_in(clk_in), .req_in(dreq), .q_out(dq));
    assign {cpu_en_in, cpu_wr_in, cpu_byte_in, cpu_addr_in, cpu_wdata_in} = cq;
    assign {dma_en_in, dma_wr_in, dma_byte_in, dma_addr_in, dma_wdata_in} = dq;
    dpr_ram dut (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .cpu_en_in(cpu_en_in), .cpu_wr_in(cpu_wr_in), .cpu_byte_in(cpu_byte_in),
        .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in),
        .cpu_rdata_out(cpu_rdata_out), .cpu_ready_out(cpu_ready_out),
        .cpu_hit_out(cpu_hit_out),
        .dma_en_in(dma_en_in), .dma_wr_in(dma_wr_in), .dma_byte_in(dma_byte_in),
        .dma_addr_in(dma_addr_in), .dma_wdata_in(dma_wdata_in),
        .dma_rdata_out(dma_rdata_out), .dma_hit_out(dma_hit_out),
        .dma_lost_out(dma_lost_out)
    );
    function [1:0] lanes(input [34:0] q);
        lanes = !(q[34] && q[33] && q[31:27] == 5'h07) ? 2'h0 : q[32] ? {q[16], !q[16]} : 2'h3;
    endfunction
    function [15:0] rd(input [34:0] q);
        reg [15:0] w;
        begin
            w = mem[q[26:17]];
            rd = (!q[34] || q[33] || q[31:27] != 5'h07) ? 16'h0 : !q[32] ? w
                : q[16] ? {8'h0, w[15:8]} : {8'h0, w[7:0]};
        end
    endfunction
    function [34:0] rq(input [31:0] v);
        rq = {v[0] | v[1], v[2], v[3], v[6:4] == 3'h0 ? v[31:16] : {12'h380, v[19:16]}, v[15:0]};
    endfunction
    task put(input [34:0] q, input [1:0] m);
        reg [15:0] k;
        begin
            k = {{8{m[1]}}, {8{m[0]}}};
            mem[q[26:17]] = mem[q[26:17]] & ~k | q[15:0] & k;
        end
    endtask
    task chk(input [8*5:1] nm, input [15:0] e, input [15:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task step(input [34:0] c, input [34:0] d);
        reg [1:0] cm, dm;
        begin
            @(posedge clk_in);
            #1;
            chk("rdy", 16'h1, cpu_ready_out);
            chk("chit", eh[2], cpu_hit_out);
            chk("dhit", eh[1], dma_hit_out);
            chk("lost", eh[0], dma_lost_out);
            chk("cdata", ec[1], cpu_rdata_out);
            chk("ddata", ed[1], dma_rdata_out);
            ec[1] = ec[0];
            ed[1] = ed[0];
            ec[0] = rd(c);
            ed[0] = rd(d);
            cm = lanes(c);
            dm = lanes(d);
            eh = {c[34] && c[31:27] == 5'h07, d[34] && d[31:27] == 5'h07, (cm & dm) != 2'h0
                && c[26:17] == d[26:17]};
            put(d, eh[0] ? dm & ~cm : dm);
            put(c, cm);
            creq = c;
            dreq = d;
        end
    endtask
    task complete_run;
        begin
            $display("compared %0d mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            miscompares = miscompares + 1;
            complete_run;
        end
    end
    initial begin
        {ec[0], ec[1], ed[0], ed[1]} = 64'h0;
        repeat (20) @(posedge clk_in);
        @(negedge clk_in);
        resetn_in = 1'b1;
        for (i = 0; i < 1024; i = i + 1) begin
            r = $random(seed);
            step({3'h6, 5'h07, i[9:0], 1'b0, r[15:0]}, 35'h0);
        end
        step({3'h6, 16'h3ffe, 16'hbeef}, {3'h6, 16'h3ffe, 16'h1234});
        step({3'h4, 16'h3ffe, 16'h0}, {3'h4, 16'h3ffe, 16'h0});
        step({3'h7, 16'h3801, 16'h5a00}, {3'h6, 16'h3800, 16'h00c3});
        step({3'h6, 16'h37fe, 16'h1111}, {3'h5, 16'h3801, 16'h0});
        step({3'h4, 16'h37fe, 16'h0}, {3'h4, 16'h3800, 16'h0});
        step(35'h0, 35'h0);
        step(35'h0, 35'h0);
        // Mid-run reset drops the word just read; RAM contents ride through it
        resetn_in = 1'b0;
        #1;
        chk("rstd", 16'h0, dma_rdata_out);
        chk("rstf", 16'h8, {cpu_ready_out, cpu_hit_out, dma_hit_out, dma_lost_out});
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        resetn_in = 1'b1;
        for (i = 0; i < 2000; i = i + 1)
            step(rq($random(seed)), rq($random(seed)));
        step(35'h0, 35'h0);
        step(35'h0, 35'h0);
        complete_run;
    end
endmodule
